// ==== design/sfce_engine.v ====
// Command engine of a 64K x 8 serial memory acting as an SPI slave.
// Assumes serial pins arrive asynchronously; serial clock well below core clock / 8.
`timescale 1ns/10ps
`default_nettype none
`include "sfce_map.vh"
module sfce_engine (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Serial pins
  input wire sck_i,
  input wire cs_n_i,
  input wire si_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o,
  // Status visibility
  output reg asleep_o,
  output reg waking_o,
  output wire [7:0] status_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_OPCODE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_SRWR = 3'h5;
  localparam ST_IGNORE = 3'h6;

  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire hold_n_s;
  wire wp_n_s;
  reg sck_d_reg;
  reg cs_n_d_reg;
  reg [2:0] state_reg;
  reg [7:0] opcode_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_reg;
  reg [1:0] byte_reg;
  reg [15:0] addr_reg;
  reg [7:0] tx_reg;
  reg [3:0] id_idx_reg;
  reg wel_reg;
  reg ppe_reg;
  reg [1:0] bp_reg;
  reg paused_reg;
  reg stalled_reg;
  reg sleep_arm_reg;
  reg [`SFCE_WAKE_W-1:0] wake_cnt_reg;
  reg [7:0] mem [0:65535];
  reg [7:0] id_byte;
  reg addr_prot;
  wire [7:0] rx_byte;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire active;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  sfce_pin_sync #(.RST_VAL(1'b0)) u_sck (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pin_i(sck_i), .level_o(sck_s));
  sfce_pin_sync #(.RST_VAL(1'b1)) u_cs (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pin_i(cs_n_i), .level_o(cs_n_s));
  sfce_pin_sync #(.RST_VAL(1'b0)) u_si (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pin_i(si_i), .level_o(si_s));
  sfce_pin_sync #(.RST_VAL(1'b1)) u_hold (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pin_i(hold_n_i), .level_o(hold_n_s));
  sfce_pin_sync #(.RST_VAL(1'b1)) u_wp (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pin_i(wp_n_i), .level_o(wp_n_s));

  // ----------------------------------------
  // Edge detection and qualifiers
  // ----------------------------------------
  // Edges seen only while selected and not paused; the first rising edge in mode 3
  // follows a falling one, so sampling on every rise covers both modes
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;
  assign cs_rise = cs_n_s & ~cs_n_d_reg;
  assign active = ~cs_n_s & ~paused_reg & ~asleep_o & ~waking_o;
  assign rx_byte = {shift_reg[6:0], si_s};
  assign status_o = `SFCE_SR_FIXED | {ppe_reg, 3'h0, bp_reg, wel_reg, 1'b0};

  // Block protection decode on the current write address
  always @* begin
    case (bp_reg)
      `SFCE_BP_NONE: addr_prot = 1'b0;
      `SFCE_BP_QUARTER: addr_prot = (addr_reg >= `SFCE_PROT_QUARTER);
      `SFCE_BP_HALF: addr_prot = (addr_reg >= `SFCE_PROT_HALF);
      default: addr_prot = 1'b1;
    endcase
  end

  // Identification byte table: continuation, maker, product code
  always @* begin
    if (id_idx_reg <= `SFCE_ID_CONT_LAST) begin
      id_byte = `SFCE_ID_CONT;
    end else if (id_idx_reg == `SFCE_ID_CONT_LAST + 4'h1) begin
      id_byte = `SFCE_ID_MFR;
    end else if (id_idx_reg == `SFCE_ID_CONT_LAST + 4'h2) begin
      id_byte = {`SFCE_ID_FAMILY, `SFCE_ID_DENSITY};
    end else if (id_idx_reg == `SFCE_ID_LAST) begin
      id_byte = {`SFCE_ID_SUB, `SFCE_ID_REV, 3'h0};
    end else begin
      id_byte = 8'h00;
    end
  end

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  // Byte stored the cycle its eighth bit lands; no buffer, no busy time
  always @(posedge core_clk_i) begin
    if (active && sck_rise && state_reg == ST_WDATA && bit_reg == `SFCE_BIT_LAST &&
        wel_reg && !addr_prot) begin
      mem[addr_reg] <= rx_byte;
    end
  end

  // ----------------------------------------
  // Pause, sleep and wakeup
  // ----------------------------------------
  // Pause level only changes while the serial clock is low
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sck_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
      paused_reg <= 1'b0;
      asleep_o <= 1'b0;
      waking_o <= 1'b0;
      wake_cnt_reg <= {`SFCE_WAKE_W{1'b0}};
    end else begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
      if (!sck_s) begin
        paused_reg <= ~hold_n_s;
      end
      if (cs_rise && sleep_arm_reg) begin
        asleep_o <= 1'b1;
      end else if (asleep_o && cs_fall) begin
        asleep_o <= 1'b0;
        waking_o <= 1'b1;
        wake_cnt_reg <= `SFCE_WAKE_CYC;
      end else if (waking_o) begin
        if (wake_cnt_reg == {`SFCE_WAKE_W{1'b0}}) begin
          waking_o <= 1'b0;
        end else begin
          wake_cnt_reg <= wake_cnt_reg - {{(`SFCE_WAKE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // Frame ends on select rise; partial bytes are simply dropped
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_OPCODE;
      opcode_reg <= 8'h00;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      addr_reg <= 16'h0000;
      tx_reg <= 8'h00;
      id_idx_reg <= 4'h0;
      wel_reg <= 1'b0;
      ppe_reg <= 1'b0;
      bp_reg <= 2'h0;
      sleep_arm_reg <= 1'b0;
      stalled_reg <= 1'b0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= ST_OPCODE;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      stalled_reg <= 1'b0;
      so_oe_o <= 1'b0;
      sleep_arm_reg <= 1'b0;
      // Latch clears on the select rise after any write command
      if (cs_rise && (opcode_reg == `SFCE_OP_WR_DISABLE || opcode_reg == `SFCE_OP_STAT_WR ||
          opcode_reg == `SFCE_OP_WRITE)) begin
        wel_reg <= 1'b0;
      end
      opcode_reg <= 8'h00;
    end else if (active) begin
      so_oe_o <= (state_reg == ST_RDATA);
      // Output shifts on the falling edge, MSB first
      if (sck_fall && state_reg == ST_RDATA) begin
        so_o <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (sck_rise) begin
        shift_reg <= rx_byte;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == `SFCE_BIT_LAST) begin
          case (state_reg)
            ST_OPCODE: begin
              opcode_reg <= rx_byte;
              case (rx_byte)
                `SFCE_OP_WR_ENABLE: wel_reg <= 1'b1;
                `SFCE_OP_WR_DISABLE: state_reg <= ST_IGNORE;
                `SFCE_OP_SLEEP: sleep_arm_reg <= 1'b1;
                `SFCE_OP_STAT_RD: begin
                  state_reg <= ST_RDATA;
                  tx_reg <= status_o;
                end
                `SFCE_OP_STAT_WR: state_reg <= ST_SRWR;
                `SFCE_OP_READ, `SFCE_OP_FAST_READ, `SFCE_OP_WRITE: state_reg <= ST_ADDR;
                `SFCE_OP_IDENT: begin
                  state_reg <= ST_RDATA;
                  tx_reg <= `SFCE_ID_CONT;
                  id_idx_reg <= 4'h1;
                end
                default: state_reg <= ST_IGNORE;
              endcase
            end
            ST_ADDR: begin
              addr_reg <= {addr_reg[7:0], rx_byte};
              byte_reg <= byte_reg + 2'h1;
              if (byte_reg + 2'h1 == `SFCE_ADDR_END) begin
                // Two address bytes, high first
                if (opcode_reg == `SFCE_OP_WRITE) begin
                  state_reg <= ST_WDATA;
                end else if (opcode_reg == `SFCE_OP_FAST_READ) begin
                  state_reg <= ST_DUMMY;
                end else begin
                  state_reg <= ST_RDATA;
                  tx_reg <= mem[{addr_reg[7:0], rx_byte}];
                end
              end
            end
            ST_DUMMY: begin
              state_reg <= ST_RDATA;
              tx_reg <= mem[addr_reg];
            end
            ST_WDATA: begin
              // Increment only while outside protection; then drop the rest
              if (!addr_prot || !wel_reg) begin
                stalled_reg <= stalled_reg;
              end
              if (addr_prot) begin
                stalled_reg <= 1'b1;
              end else if (!stalled_reg) begin
                addr_reg <= addr_reg + 16'h0001;
              end
            end
            ST_SRWR: begin
              // Write protect pin guards only this register
              if (wel_reg && !(ppe_reg && !wp_n_s)) begin
                ppe_reg <= rx_byte[`SFCE_SR_PPE];
                bp_reg <= {rx_byte[`SFCE_SR_BPHI], rx_byte[`SFCE_SR_BPLO]};
              end
              state_reg <= ST_IGNORE;
            end
            ST_RDATA: begin
              // Serial input ignored; next byte loaded, address wraps
              if (opcode_reg == `SFCE_OP_STAT_RD) begin
                tx_reg <= status_o;
              end else if (opcode_reg == `SFCE_OP_IDENT) begin
                tx_reg <= id_byte;
                id_idx_reg <= (id_idx_reg == `SFCE_ID_LAST) ? 4'h0 : id_idx_reg + 4'h1;
              end else begin
                tx_reg <= mem[addr_reg + 16'h0001];
                addr_reg <= addr_reg + 16'h0001;
              end
            end
            default: state_reg <= ST_IGNORE;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/sfce_map.vh ====
// Constants for the serial ferroelectric memory command engine.
// Assumes a single core clock domain; serial pins are sampled, not used as clocks.
//
// Overview of operation
// - Status read returns one status byte
// - Status write updates protect enable, block bits
// - Protect pin blocks only status register writes
// - Status write clears write enable latch
// - Enable frame, then write opcode, address, data
// - Write address increments, wraps, MSB first
// - Select rising ends memory write
// - Protected address stops increment, drops data
// - Byte stored at eighth bit, partial dropped
// - Read data after address, input ignored
// - Read address increments, wraps, MSB first
// - Select rising ends read, output released
// - Fast read adds one dummy byte
// - Fast read ends on select rising
// - Pause input suspends, resumes while clock low
// - Sleep opcode then select rising sleeps
// - Asleep: ignore clock, input; output released
// - Select falling wakes after recovery time
// - Ident read returns nine read-only bytes
// - Product code holds family, density, sub, rev
// - Latch clears on select rise after writes
// - Block codes protect none, quarter, half, all
// - Clock level at select picks mode 0/3
`ifndef SFCE_MAP_VH
`define SFCE_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFCE_OP_WR_ENABLE 8'h06
`define SFCE_OP_WR_DISABLE 8'h04
`define SFCE_OP_STAT_RD 8'h05
`define SFCE_OP_STAT_WR 8'h01
`define SFCE_OP_READ 8'h03
`define SFCE_OP_FAST_READ 8'h0b
`define SFCE_OP_WRITE 8'h02
`define SFCE_OP_SLEEP 8'hb9
`define SFCE_OP_IDENT 8'h9f

// ----------------------------------------
// Status register layout
// ----------------------------------------
`define SFCE_SR_PPE 7
`define SFCE_SR_BPHI 3
`define SFCE_SR_BPLO 2
`define SFCE_SR_LATCH 1
`define SFCE_SR_FIXED 8'h40

// ----------------------------------------
// Protection boundaries
// ----------------------------------------
`define SFCE_PROT_QUARTER 16'hc000
`define SFCE_PROT_HALF 16'h8000
`define SFCE_BP_NONE 2'h0
`define SFCE_BP_QUARTER 2'h1
`define SFCE_BP_HALF 2'h2

// ----------------------------------------
// Identification (values arbitrary, neutral)
// ----------------------------------------
`define SFCE_ID_CONT 8'h5a
`define SFCE_ID_MFR 8'h3c
`define SFCE_ID_FAMILY 3'h1
`define SFCE_ID_DENSITY 5'h03
`define SFCE_ID_SUB 2'h0
`define SFCE_ID_REV 3'h0
`define SFCE_ID_LAST 4'h8
`define SFCE_ID_CONT_LAST 4'h5

// ----------------------------------------
// Timing
// ----------------------------------------
// Wakeup recovery of 400 ns at a 50 MHz core clock, kept sized for the counter
`define SFCE_WAKE_CYC 8'h14
`define SFCE_WAKE_W 8

// ----------------------------------------
// Byte counts
// ----------------------------------------
`define SFCE_BIT_LAST 3'h7
`define SFCE_ADDR_END 2'h2
`define SFCE_DUMMY_END 2'h3

`endif

// ==== design/sfce_pin_sync.v ====
// Pin synchroniser: three flip-flops and an output flip-flop, a change counts once stages two and three agree.
// Assumes the input is asynchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module sfce_pin_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Pin and filtered level
  input wire pin_i,
  output reg level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------
  // Sampling chain
  // ----------------------------------------
  // Stage one feeds stage two only, to keep metastability contained
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/sfce_engine_assertions.sv ====
// Checker for the command engine's pins and status byte.
// Assumes one core clock domain; bound to every engine instance.
`timescale 1ns/10ps
`default_nettype none
module sfce_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Watched pins
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic so_oe_o,
  input wire logic asleep_o,
  input wire logic waking_o,
  input wire logic [7:0] status_o
);
  // ------------------------
  // Properties
  // ------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Long enough for the select synchroniser to catch up
  sequence s_cs_idle;
    cs_n_i [*8];
  endsequence
  sequence s_sr_locked;
    (status_o[7] && !wp_n_i) [*6];
  endsequence
  property p_fixed_bits;
    status_o[6:4] == 3'h4 && !status_o[0];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong");
  property p_idle_hiz;
    s_cs_idle |-> !so_oe_o;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while idle");
  property p_sleep_hiz;
    (asleep_o || waking_o) |-> !so_oe_o;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("output driven in sleep");
  // Recovery holds waking for 21 cycles; a little slack up to 25
  property p_wake_len;
    $rose(waking_o) |-> ##[1:25] !waking_o;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wakeup too long");
  property p_wake_start;
    $rose(waking_o) |-> !cs_n_i;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wakeup without select");
  property p_sleep_on_cs;
    $rose(asleep_o) |-> cs_n_i;
  endproperty
  a_sleep_on_cs: assert property (p_sleep_on_cs) else $error("sleep before select rise");
  property p_wel_fall;
    $fell(status_o[1]) |-> cs_n_i;
  endproperty
  a_wel_fall: assert property (p_wel_fall) else $error("latch cleared in frame");
  property p_sr_locked;
    s_sr_locked |=> $stable(status_o[7:2]);
  endproperty
  a_sr_locked: assert property (p_sr_locked) else $error("status changed while locked");
endmodule

bind sfce_engine sfce_checker sfce_checker_inst (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .cs_n_i(cs_n_i),
  .wp_n_i(wp_n_i),
  .so_oe_o(so_oe_o),
  .asleep_o(asleep_o),
  .waking_o(waking_o),
  .status_o(status_o)
);
`default_nettype wire

// ==== sim/sfce_spi_master.sv ====
// SPI bus master model for the command engine's serial pins.
// Assumes a 20 ns core clock; serial clock is eight core clocks.
`timescale 1ns/10ps
`default_nettype none
module sfce_spi_master (
  // Clock
  input wire logic core_clk_i,
  // Serial pins
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  // ------------------------
  // Frame tasks
  // ------------------------
  logic idle = 1'b0; // Idle clock level, high picks mode 3
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // Pins move only after a core clock falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Select with the clock parked at its idle level
  task automatic sel();
    tick(1);
    sck_o = idle;
    tick(4);
    cs_n_o = 1'b0;
    tick(4);
  endtask
  // Data line shows junk once released, never its last bit
  task automatic desel();
    tick(1);
    sck_o = idle;
    tick(4);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(12);
  endtask
  // Sample late in the high phase, where output has settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      tick(1);
      sck_o = 1'b0;
      si_o = tx[i];
      tick(4);
      sck_o = 1'b1;
      tick(3);
      rx[i] = so_i;
    end
  endtask
  // Pause changes only with the clock low
  task automatic hold(input logic v);
    tick(1);
    sck_o = 1'b0;
    tick(4);
    hold_n_o = v;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the serial memory command engine.
// Assumes the master model and the bound checker are compiled too.
`timescale 1ns/10ps
`default_nettype none
`include "sfce_map.vh"
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n = 1'b1;
  logic [7:0] rx;
  int fails = 0;
  int checked = 0;
  wire logic sck, cs_n, si, hold_n, so, so_oe, asleep, waking, so_line;
  wire logic [7:0] status;
  // Line floats whenever the engine lets go of it
  assign so_line = so_oe ? so : 1'bz;
  sfce_engine sfce_engine_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
    .so_oe_o(so_oe), .asleep_o(asleep), .waking_o(waking), .status_o(status));
  sfce_spi_master sfce_spi_master_inst (.core_clk_i(core_clk_i), .so_i(so_line),
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  // ------------------------
  // Tasks
  // ------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic x(input logic [7:0] t);
    sfce_spi_master_inst.xfer(t, rx);
  endtask
  task automatic rd(input logic [7:0] e);
    x(8'h5a);
    chk("rdata", rx, e);
  endtask
  task automatic fin();
    sfce_spi_master_inst.desel();
  endtask
  task automatic one(input logic [7:0] o);
    sfce_spi_master_inst.sel();
    x(o);
    fin();
  endtask
  task automatic op(input logic [7:0] o, input logic [15:0] a);
    sfce_spi_master_inst.sel();
    x(o);
    x(a[15:8]);
    x(a[7:0]);
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    one(`SFCE_OP_WR_ENABLE);
    sfce_spi_master_inst.sel();
    x(`SFCE_OP_STAT_WR);
    x(v);
    fin();
  endtask
  task automatic rsr(input logic [7:0] e);
    sfce_spi_master_inst.sel();
    x(`SFCE_OP_STAT_RD);
    rd(e);
    fin();
  endtask
  // Hang guard, well past the few thousand cycles the tests need
  initial begin
    #400000;
    fails++;
    final_report();
  end
  // ------------------------
  // Tests
  // ------------------------
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    chk("status", status, 8'h40);
    rsr(8'h40);
    one(`SFCE_OP_WR_ENABLE);
    op(`SFCE_OP_WRITE, 16'hbffe);
    x(8'h11);
    x(8'h22);
    x(8'hcc);
    fin();
    one(`SFCE_OP_WR_ENABLE);
    op(`SFCE_OP_WRITE, 16'hffff);
    x(8'h5a);
    x(8'ha5);
    fin();
    chk("status", status, 8'h40);
    op(`SFCE_OP_READ, 16'hbffe);
    rd(8'h11);
    rd(8'h22);
    rd(8'hcc);
    fin();
    chk("oe", {7'h00, so_oe}, 8'h00);
    op(`SFCE_OP_FAST_READ, 16'hffff);
    x(8'h00);
    rd(8'h5a);
    rd(8'ha5);
    fin();
    chk("oe", {7'h00, so_oe}, 8'h00);
    status_write_cmd(8'h84);
    chk("status", status, 8'hc4);
    wp_n = 1'b0;
    status_write_cmd(8'h00);
    chk("status", status, 8'hc4);
    one(`SFCE_OP_WR_ENABLE);
    op(`SFCE_OP_WRITE, 16'hbffe);
    x(8'h33);
    x(8'h44);
    x(8'h77);
    x(8'h88);
    fin();
    wp_n = 1'b1;
    op(`SFCE_OP_READ, 16'hbffe);
    rd(8'h33);
    rd(8'h44);
    rd(8'hcc);
    fin();
    one(`SFCE_OP_WR_ENABLE);
    op(`SFCE_OP_WRITE, 16'h0100);
    x(8'h3c);
    sfce_spi_master_inst.hold(1'b0);
    x(8'hff);
    sfce_spi_master_inst.hold(1'b1);
    x(8'hc3);
    fin();
    op(`SFCE_OP_READ, 16'h0100);
    rd(8'h3c);
    rd(8'hc3);
    fin();
    sfce_spi_master_inst.sel();
    x(`SFCE_OP_IDENT);
    for (int i = 0; i < 9; i++) begin
      rd(i < 6 ? `SFCE_ID_CONT : i == 6 ? `SFCE_ID_MFR :
        i == 7 ? {`SFCE_ID_FAMILY, `SFCE_ID_DENSITY} : {`SFCE_ID_SUB, `SFCE_ID_REV, 3'h0});
    end
    fin();
    sfce_spi_master_inst.sel();
    x(8'h77);
    x(8'h00);
    chk("oe", {7'h00, so_oe}, 8'h00);
    fin();
    one(`SFCE_OP_SLEEP);
    chk("asleep", {7'h00, asleep}, 8'h01);
    sfce_spi_master_inst.sel();
    x(`SFCE_OP_READ);
    chk("oe", {7'h00, so_oe}, 8'h00);
    fin();
    repeat (30) @(negedge core_clk_i);
    chk("wake", {6'h00, asleep, waking}, 8'h00);
    sfce_spi_master_inst.idle = 1'b1;
    rsr(8'hc4);
    final_report();
  end
endmodule
`default_nettype wire
